//--- src/csis_pkg.sv
// csis_pkg: shared constants and types for the sequencer block
// assumes one core clock domain and a wishbone register slave
package csis_pkg;
   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int          PC_W      = 11;
   localparam int          SP_W      = 4;
   // pc holds the offset inside program space; offset 0 is 0x800
   localparam logic [11:0] PROG_BASE = 12'h800;
   localparam logic [10:0] PC_RST    = 11'h000;
   localparam logic [3:0]  SP_RST    = 4'hF;
   localparam logic [7:0]  STK_BASE  = 8'h30;
   localparam logic [5:0]  SR_RST    = 6'h00;
   localparam logic [10:0] BR_BIAS   = 11'h01F;
   // ----------------------------------------------------------------
   // register offsets (byte addresses) and status bit positions
   // ----------------------------------------------------------------
   localparam logic [3:0]  ADR_SP    = 4'h0;
   localparam logic [3:0]  ADR_SR    = 4'h4;
   localparam logic [3:0]  ADR_PEND  = 4'h8;
   localparam logic [3:0]  ADR_PC    = 4'hC;
   localparam int          F_C       = 0;
   localparam int          F_H       = 1;
   localparam int          F_Z       = 2;
   localparam int          F_N       = 3;
   localparam int          F_G       = 4;
   localparam int          F_R       = 5;
   // ----------------------------------------------------------------
   // commands, addressing modes, states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NEXT, OP_CALL, OP_RET, OP_IRQ_EXIT, OP_TRAP, OP_JUMP, OP_BRANCH,
      OP_SETG, OP_LDC, OP_FLIP_CARRY_BIT, OP_SETC, OP_CLRC
   } csis_op_t;
   typedef enum logic [1:0] {
      AM_INDEXED, AM_INDIRECT, AM_DIRECT, AM_ABS
   } csis_mode_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_PUSH_LO, ST_PUSH_HI, ST_VECTOR,
      ST_POP_HI, ST_POP_LO, ST_POP_END
   } csis_state_t;
endpackage

//--- src/csis_core.sv
// csis_core: program counter, hardware stack, status word and
// interrupt entry/exit sequencer of an 8-bit accumulator core
// assumes a data ram with one-cycle registered read for the stack
// What this block does
// R1 - 11-bit pc, resets to offset 0x000 (address 0x800)
// R2 - 4-bit stack pointer into 0x30-0x3F
// R3 - stack pointer resets to 0xF
// R4 - push lowers stack pointer by two
// R5 - pull raises stack pointer by two
// R6 - pointer always names next free slot
// R7 - call pushes return address, low byte first
// R8 - subroutine exit reloads pc from stack
// R9 - carry from alu, rotates, load, flip
// R10 - half carry from nibble overflow
// R11 - zero flag set on zero result
// R12 - negative flag copies result msb
// R13 - mask clear: requests only pend
// R14 - reset clears mask; software alone sets
// R15 - interrupt entry within five cycles, clears mask
// R16 - interrupt exit pops pc, sets mask
// R17 - four sources; trap ignores the mask
// R18 - trap entry same as maskable entry
// R19 - priority pin change, timer0, timer1, trap
// R20 - indexed: 8-bit offset plus pointer low bits
// R21 - direct and indirect operand forms
// R22 - absolute: 11-bit address from two bytes
// R23 - pointer bit 11 picks data or program
// R24 - short branch displacement -31 to +32
// R25 - vectors are parameters; pending until vector
`timescale 1ns/10ps
module csis_core import csis_pkg::*; #(
   parameter logic [10:0] VEC_PIN  = 11'h7F0,
   parameter logic [10:0] VEC_T0   = 11'h7F2,
   parameter logic [10:0] VEC_T1   = 11'h7F4,
   parameter logic [10:0] VEC_TRAP = 11'h7F6
) (
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic             opValid,
   input  wire logic [3:0]       opKind,
   input  wire logic [7:0]       opA,
   input  wire logic [7:0]       opB,
   input  wire logic             aluWe,
   input  wire logic [7:0]       aluRes,
   input  wire logic             aluCarry,
   input  wire logic             aluHalf,
   input  wire logic             updC,
   input  wire logic             updH,
   input  wire logic [2:0]       irqReq,
   input  wire logic [11:0]      xPtr,
   input  wire logic [1:0]       addrMode,
   input  wire logic [7:0]       stkRdData,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [3:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic [31:0]           wb_dat_o,
   output logic                  wb_ack_o,
   output logic                  busy,
   output logic [PC_W-1:0]       progCounter,
   output logic [5:0]            statusWord,
   output logic                  stkWe,
   output logic                  stkRe,
   output logic [7:0]            stkAddr,
   output logic [7:0]            stkWrData,
   output logic [11:0]           effAddr
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   csis_state_t       state;
   csis_state_t       next_state;
   logic [SP_W-1:0]   stackPointer;
   logic [SP_W-1:0]   next_sp;
   logic [PC_W-1:0]   next_pc;
   logic [PC_W-1:0]   target;
   logic [2:0]        pend;
   logic              trapPend;
   logic              isCall;
   logic              isReti;
   logic [2:0]        hiByte;
   logic [SP_W-1:0]   spOff;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire idle      = (state == ST_IDLE);
   wire take      = idle && opValid;
   wire maskOn    = statusWord[F_G];
   // only a masked-on request or a trap may start an entry
   wire irqGo     = idle && !opValid
                    && (trapPend || (maskOn && |pend)); // [R13] [R17]
   wire selPin    = maskOn && pend[2];                  // [R19]
   wire selT0     = maskOn && !pend[2] && pend[1];      // [R19]
   wire selT1     = maskOn && pend[2:1] == 2'b00 && pend[0]; // [R19]
   wire selTrap   = !(selPin || selT0 || selT1);        // [R19]
   wire inVector  = (state == ST_VECTOR);
   wire [2:0] clrPend = inVector ? {selPin, selT0, selT1} : 3'b000;
   wire [10:0] vecAddr = selPin ? VEC_PIN :
                         selT0  ? VEC_T0  :
                         selT1  ? VEC_T1  : VEC_TRAP;    // [R25]
   wire [10:0] absAddr = {opB[2:0], opA};               // [R22]
   wire [10:0] brAddr  = progCounter + {3'h0, 2'b00, opA[5:0]}
                         - BR_BIAS;                      // [R24]
   wire [10:0] popAddr = {hiByte, stkRdData};

   // ----------------------------------------------------------------
   // register bus decode
   // ----------------------------------------------------------------
   wire wbHit    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wbWr     = wbHit && wb_we_i && wb_sel_i[0];
   wire wrSp     = wbWr && wb_adr_i == ADR_SP;          // [R2]
   wire wrSr     = wbWr && wb_adr_i == ADR_SR;
   wire [31:0] rdMux =
      wb_adr_i == ADR_SP   ? {28'h0, stackPointer} :
      wb_adr_i == ADR_SR   ? {26'h0, statusWord} :
      wb_adr_i == ADR_PEND ? {28'h0, trapPend, pend} :
      wb_adr_i == ADR_PC   ? {21'h0, progCounter} : 32'h0;

   // ----------------------------------------------------------------
   // sequencer next state, pc and stack pointer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_pc    = progCounter;
      next_sp    = wrSp ? wb_dat_i[SP_W-1:0] : stackPointer; // [R2]
      case (state)
         ST_IDLE: begin
            if (take) begin
               case (opKind)
                  OP_NEXT:   next_pc = progCounter + 11'h001;
                  OP_JUMP:   next_pc = absAddr;          // [R22]
                  OP_BRANCH: next_pc = brAddr;           // [R24]
                  OP_CALL, OP_TRAP: next_state = ST_PUSH_LO; // [R7] [R18]
                  OP_RET, OP_IRQ_EXIT:  next_state = ST_POP_HI;  // [R8] [R16]
                  default: ;
               endcase
            end else if (irqGo) begin
               next_state = ST_PUSH_LO;                  // [R15]
            end
         end
         ST_PUSH_LO: next_state = ST_PUSH_HI;
         ST_PUSH_HI: begin
            next_sp    = stackPointer - 4'h2;            // [R4]
            next_state = isCall ? ST_IDLE : ST_VECTOR;
            if (isCall) begin
               next_pc = target;
            end
         end
         ST_VECTOR: begin
            next_pc    = vecAddr;                        // [R15] [R25]
            next_state = ST_IDLE;
         end
         ST_POP_HI: next_state = ST_POP_LO;
         ST_POP_LO: next_state = ST_POP_END;
         ST_POP_END: begin
            next_sp    = stackPointer + 4'h2;            // [R5]
            next_pc    = popAddr;                        // [R8] [R16]
            next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // stack slot offset for the access about to be issued
   always_comb begin
      case (next_state)
         ST_PUSH_HI: spOff = stackPointer - 4'h1;
         ST_POP_HI:  spOff = stackPointer + 4'h1;
         ST_POP_LO:  spOff = stackPointer + 4'h2;
         default:    spOff = stackPointer;               // [R6]
      endcase
   end

   wire nextWe = next_state == ST_PUSH_LO || next_state == ST_PUSH_HI;
   wire nextRe = next_state == ST_POP_HI || next_state == ST_POP_LO;
   // low byte leaves first so the pull sees high byte first
   wire [7:0] nextWrData = next_state == ST_PUSH_HI ?
                           {5'h00, progCounter[10:8]} :
                           progCounter[7:0];             // [R7]

   // ----------------------------------------------------------------
   // sequencer registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state        <= ST_IDLE;
         progCounter  <= PC_RST;                         // [R1]
         stackPointer <= SP_RST;                         // [R3]
         busy         <= 1'b0;
      end else begin
         state        <= next_state;
         progCounter  <= next_pc;
         stackPointer <= next_sp;
         busy         <= next_state != ST_IDLE;
      end
   end

   // stack port, registered so the ram sees clean strobes
   always_ff @(posedge core_clk) begin
      if (srst) begin
         stkWe     <= 1'b0;
         stkRe     <= 1'b0;
         stkAddr   <= STK_BASE;
         stkWrData <= 8'h00;
      end else begin
         stkWe     <= nextWe;                            // [R6]
         stkRe     <= nextRe;
         stkAddr   <= STK_BASE | {4'h0, spOff};          // [R2]
         stkWrData <= nextWrData;
      end
   end

   // command context held across the multi-cycle sequences
   always_ff @(posedge core_clk) begin
      if (srst) begin
         target <= PC_RST;
         isCall <= 1'b0;
         isReti <= 1'b0;
         hiByte <= 3'h0;
      end else begin
         if (idle) begin
            target <= absAddr;
            isCall <= take && opKind == OP_CALL;
            isReti <= take && opKind == OP_IRQ_EXIT;
         end
         if (state == ST_POP_LO) begin
            hiByte <= stkRdData[2:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // pending requests; a new request beats the clear
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pend     <= 3'b000;
         trapPend <= 1'b0;
      end else begin
         pend <= (pend & ~clrPend) | irqReq;             // [R13] [R25]
         if (take && opKind == OP_TRAP) begin
            trapPend <= 1'b1;                            // [R17]
         end else if (inVector && selTrap) begin
            trapPend <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // status word; alu update wins over a bus write
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         statusWord <= SR_RST;                           // [R14]
      end else begin
         if (wrSr) begin
            statusWord <= wb_dat_i[5:0];                 // [R14]
         end
         if (aluWe) begin
            statusWord[F_Z] <= aluRes == 8'h00;          // [R11]
            statusWord[F_N] <= aluRes[7];                // [R12]
            if (updC) begin
               statusWord[F_C] <= aluCarry;              // [R9]
            end
            if (updH) begin
               statusWord[F_H] <= aluHalf;               // [R10]
            end
         end
         if (take) begin
            case (opKind)
               OP_SETG: statusWord[F_G] <= 1'b1;         // [R14]
               OP_LDC:  statusWord[F_C] <= opA[0];       // [R9]
               OP_FLIP_CARRY_BIT: statusWord[F_C] <= ~statusWord[F_C]; // [R9]
               OP_SETC: statusWord[F_C] <= 1'b1;
               OP_CLRC: statusWord[F_C] <= 1'b0;
               default: ;
            endcase
         end
         if (inVector) begin
            statusWord[F_G] <= 1'b0;                     // [R15] [R18]
         end
         if (state == ST_POP_END && isReti) begin
            statusWord[F_G] <= 1'b1;                     // [R16]
         end
      end
   end

   // ----------------------------------------------------------------
   // operand address forms; in indexed mode bit 11 of the pointer picks the space
   // ----------------------------------------------------------------
   wire [10:0] idxSum = xPtr[10:0] + {3'h0, opA};        // [R20]
   wire [11:0] nextEff =
      addrMode == AM_INDEXED  ? {xPtr[11], idxSum} :     // [R20] [R23]
      addrMode == AM_INDIRECT ? {4'h0, xPtr[7:0]} :      // [R21]
      addrMode == AM_DIRECT   ? {4'h0, opA} :            // [R21]
                                (PROG_BASE | {1'b0, absAddr}); // [R22]

   always_ff @(posedge core_clk) begin
      if (srst) begin
         effAddr <= 12'h000;
      end else begin
         effAddr <= nextEff;
      end
   end

   // ----------------------------------------------------------------
   // wishbone slave: answer one cycle after the request
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wbHit;
         wb_dat_o <= wbHit ? rdMux : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   property p_pc_reset; // [R1]
      $fell(srst) |-> progCounter == PC_RST && idle;
   endproperty
   a_pc_reset: assert property (p_pc_reset) else $error("pc reset"); // [R1]

   property p_sp_reset; // [R3]
      $fell(srst) |-> stackPointer == SP_RST && !statusWord[F_G];
   endproperty
   a_sp_reset: assert property (p_sp_reset) else $error("sp reset"); // [R3]

   sequence s_push_lo;
      stkWe && stkAddr == (STK_BASE | {4'h0, stackPointer})
      && stkWrData == progCounter[7:0];
   endsequence
   sequence s_push_hi;
      stkWe && stkWrData == {5'h00, progCounter[10:8]};
   endsequence
   property p_push_order; // [R7]
      state == ST_PUSH_LO |-> s_push_lo ##1 s_push_hi;
   endproperty
   a_push_order: assert property (p_push_order) else $error("push"); // [R7]

   property p_push_dec; // [R4]
      state == ST_PUSH_HI |=> stackPointer == $past(stackPointer) - 4'h2;
   endproperty
   a_push_dec: assert property (p_push_dec) else $error("push sp"); // [R4]

   property p_pop_inc; // [R5]
      state == ST_POP_END |=> stackPointer == $past(stackPointer) + 4'h2;
   endproperty
   a_pop_inc: assert property (p_pop_inc) else $error("pop sp"); // [R5]

   property p_ret_pc; // [R8]
      state == ST_POP_END |=> progCounter == $past(popAddr) && idle;
   endproperty
   a_ret_pc: assert property (p_ret_pc) else $error("return pc"); // [R8]

   property p_irq_exit_g; // [R16]
      state == ST_POP_END && isReti |=> statusWord[F_G];
   endproperty
   a_irq_exit_g: assert property (p_irq_exit_g) else $error("irq_exit mask"); // [R16]

   property p_masked; // [R13]
      idle && !opValid && !trapPend && !maskOn |=> idle;
   endproperty
   a_masked: assert property (p_masked) else $error("masked entry"); // [R13]

   property p_entry; // [R15]
      irqGo |-> ##[1:4] (inVector ##1 (idle && !statusWord[F_G]));
   endproperty
   a_entry: assert property (p_entry) else $error("entry time"); // [R15]

   property p_trap; // [R17]
      take && opKind == OP_TRAP |-> ##3 inVector;
   endproperty
   a_trap: assert property (p_trap) else $error("trap entry"); // [R17]

   property p_prio; // [R19]
      inVector && maskOn && pend[2] |=> progCounter == VEC_PIN;
   endproperty
   a_prio: assert property (p_prio) else $error("priority"); // [R19]

   property p_flags; // [R11]
      aluWe |=> statusWord[F_Z] == ($past(aluRes) == 8'h00)
                && statusWord[F_N] == $past(aluRes[7]);
   endproperty
   a_flags: assert property (p_flags) else $error("zero/neg"); // [R11]

   property p_half; // [R10]
      aluWe && updH |=> statusWord[F_H] == $past(aluHalf);
   endproperty
   a_half: assert property (p_half) else $error("half carry"); // [R10]
endmodule // csis_core

//--- tb/csis_stack_ram.sv
// csis_stack_ram: behavioural data ram window behind the stack port
// assumes registered strobes from the core and one-cycle read latency
`timescale 1ns/10ps
module csis_stack_ram (
   input  wire logic       core_clk,
   input  wire logic       stkWe,
   input  wire logic       stkRe,
   input  wire logic [7:0] stkAddr,
   input  wire logic [7:0] stkWrData,
   output logic      [7:0] stkRdData
);
   // ----------------------------------------------------------------
   // storage and read port
   // ----------------------------------------------------------------
   logic [7:0] mem [0:15];
   logic [7:0] lastRd = 8'h00;

   // low nibble picks the slot; the core only reaches 0x30-0x3F
   always @(posedge core_clk) begin
      if (stkWe) begin
         mem[stkAddr[3:0]] <= stkWrData;
      end
      if (stkRe) begin
         stkRdData <= mem[stkAddr[3:0]];
         lastRd    <= mem[stkAddr[3:0]];
      end else begin
         // no stale byte outside a read, so a late sample shows up
         stkRdData <= ~lastRd;
      end
   end
endmodule // csis_stack_ram

//--- tb/testbench.sv
// testbench: self-checking bench for csis_core with a stack ram model
// assumes csis_pkg and csis_stack_ram are compiled before it
`timescale 1ns/10ps
module testbench import csis_pkg::*; ;
   localparam logic [10:0] VP  = 11'h7F0;
   localparam logic [10:0] VT0 = 11'h7F2;
   localparam logic [10:0] VT1 = 11'h7F4;
   localparam logic [10:0] VTR = 11'h7F6;
   // ----------------------------------------------------------------
   // stimulus, observed signals, expectations
   // ----------------------------------------------------------------
   logic        core_clk = 1'b0, srst = 1'b1, opValid = 1'b0;
   logic        aluWe = 1'b0, aluCarry = 1'b0, aluHalf = 1'b0;
   logic        updC = 1'b0, updH = 1'b0, stkWe, stkRe, busy;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic        wb_ack_o;
   logic [3:0]  opKind = 4'h0, wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [7:0]  opA = 8'h00, opB = 8'h00, aluRes = 8'h00;
   logic [7:0]  stkRdData, stkAddr, stkWrData;
   logic [2:0]  irqReq = 3'h0;
   logic [1:0]  addrMode = 2'h0;
   logic [11:0] xPtr = 12'h000, effAddr;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, r;
   logic [10:0] progCounter, expPc, ret;
   logic [5:0]  statusWord, expSt;
   logic [3:0]  expSp;
   logic [10:0] vecs [3];
   csis_op_t    cop [6];
   int          fails = 0, compares = 0;

   csis_core #(.VEC_PIN(VP), .VEC_T0(VT0), .VEC_T1(VT1), .VEC_TRAP(VTR))
   DUT (.core_clk, .srst, .opValid, .opKind, .opA, .opB, .aluWe,
      .aluRes, .aluCarry, .aluHalf, .updC, .updH, .irqReq, .xPtr,
      .addrMode, .stkRdData, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy, .progCounter,
      .statusWord, .stkWe, .stkRe, .stkAddr, .stkWrData, .effAddr);
   csis_stack_ram u_ram (.core_clk, .stkWe, .stkRe, .stkAddr, .stkWrData,
      .stkRdData);

   always #20 core_clk = ~core_clk;

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got,
                  exp);
      end
   endtask

   // classic single cycle; waits for ack, never assumes a latency
   task automatic wb(input logic we, input logic [3:0] adr,
                     input logic [31:0] dat, input logic [3:0] sel);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (n >= 50) chk(1'b0, 1'b1, "no ack");
   endtask

   // one command, then wait out the busy span
   task automatic op(input csis_op_t k, input logic [7:0] a,
                     input logic [7:0] b);
      int n;
      n = 0;
      @(posedge core_clk);
      opValid <= 1'b1;
      opKind  <= k;
      opA     <= a;
      opB     <= b;
      @(posedge core_clk);
      opValid <= 1'b0;
      #1;
      while (busy !== 1'b0 && n < 20) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 20) chk(1'b0, 1'b1, "busy stuck");
   endtask

   task automatic pulse(input logic [2:0] v);
      @(posedge core_clk);
      irqReq <= v;
      @(posedge core_clk);
      irqReq <= 3'h0;
      #1;
   endtask

   task automatic pushed(input logic [10:0] ra);
      chk(u_ram.mem[expSp], {24'h0, ra[7:0]}, "low byte");
      chk(u_ram.mem[expSp - 4'h1], {29'h0, ra[10:8]}, "hi byte");
      expSp = expSp - 4'h2;
      wb(1'b0, ADR_SP, 32'h0, 4'hF);
      chk(q, {28'h0, expSp}, "sp push");
   endtask

   task automatic pulled(input logic [10:0] ra);
      expSp = expSp + 4'h2;
      expPc = ra;
      chk(progCounter, expPc, "pc pull");
   endtask

   task automatic wait_entry(input logic [10:0] vec);
      int n;
      n = 0;
      while ((busy !== 1'b0 || progCounter !== vec) && n < 8) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk(n <= 5, 1'b1, "entry slow");
      chk(progCounter, vec, "vector");
      chk(statusWord[F_G], 1'b0, "mask set");
   endtask

   function automatic logic [11:0] ea(input logic [1:0] m,
      input logic [11:0] x, input logic [7:0] a, input logic [7:0] b);
      case (m)
         2'd0:    return {x[11], x[10:0] + {3'h0, a}};
         2'd1:    return {4'h0, x[7:0]};
         2'd2:    return {4'h0, a};
         default: return {1'b1, b[2:0], a};
      endcase
   endfunction

   task automatic close_out();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (6000) @(posedge core_clk);
      fails++;
      close_out();
   end

   initial begin
      void'($urandom(32'hC943));
      vecs = '{VP, VT0, VT1};
      cop = '{OP_LDC, OP_LDC, OP_FLIP_CARRY_BIT, OP_SETC, OP_FLIP_CARRY_BIT, OP_CLRC};
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      expPc = PC_RST;
      expSp = SP_RST;
      @(posedge core_clk);
      #1;
      chk(progCounter, 11'h000, "pc reset");
      chk(statusWord, 6'h00, "sr reset");
      chk(stkAddr, 8'h3F, "stack top");
      wb(1'b0, ADR_SP, 32'h0, 4'hF);
      chk(q, 32'hF, "sp reset");
      wb(1'b0, 4'h2, 32'h0, 4'hF);
      chk(q, 32'h0, "unmapped");
      wb(1'b1, ADR_SP, 32'h3, 4'hE);
      wb(1'b0, ADR_SP, 32'h0, 4'hF);
      chk(q, 32'hF, "sel ignored");
      expSp = 4'h8 + 4'($urandom % 8);
      wb(1'b1, ADR_SP, {28'h0, expSp}, 4'hF);
      wb(1'b0, ADR_SP, 32'h0, 4'hF);
      chk(q, {28'h0, expSp}, "sp load");
      r = $urandom & 32'h2F;
      expSt = r[5:0];
      wb(1'b1, ADR_SR, r, 4'hF);
      wb(1'b0, ADR_SR, 32'h0, 4'hF);
      chk(q, r, "sr rw");
      // alu flags, with zero and sign corners first
      for (int i = 0; i < 12; i++) begin
         r = $urandom;
         if (i == 0) r[7:0] = 8'h00;
         if (i == 1) r[7:0] = 8'h80;
         @(posedge core_clk);
         aluWe <= 1'b1;
         aluRes <= r[7:0];
         aluCarry <= r[8];
         aluHalf <= r[9];
         updC <= r[10];
         updH <= r[11];
         @(posedge core_clk);
         aluWe <= 1'b0;
         #1;
         expSt[F_Z] = (r[7:0] == 8'h00);
         expSt[F_N] = r[7];
         if (r[10]) expSt[F_C] = r[8];
         if (r[11]) expSt[F_H] = r[9];
         chk(statusWord, expSt, "alu flags");
      end
      foreach (cop[i]) begin
         op(cop[i], {7'h0, i[0]}, 8'h00);
         case (cop[i])
            OP_LDC:  expSt[F_C] = i[0];
            OP_FLIP_CARRY_BIT: expSt[F_C] = ~expSt[F_C];
            OP_SETC: expSt[F_C] = 1'b1;
            default: expSt[F_C] = 1'b0;
         endcase
         chk(statusWord, expSt, "carry op");
      end
      // program flow: jump, next, short branch extremes, call, return
      r = $urandom;
      op(OP_JUMP, r[7:0], r[15:8]);
      expPc = r[10:0];
      chk(progCounter, expPc, "jump");
      op(OP_NEXT, 8'h00, 8'h00);
      expPc = expPc + 11'h001;
      chk(progCounter, expPc, "next");
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         if (i < 2) r[5:0] = i[0] ? 6'h3F : 6'h00;
         op(OP_BRANCH, r[7:0], 8'h00);
         expPc = expPc + {5'h0, r[5:0]} - BR_BIAS;
         chk(progCounter, expPc, "branch");
      end
      r = $urandom;
      ret = expPc;
      op(OP_CALL, r[7:0], r[15:8]);
      pushed(ret);
      chk(progCounter, r[10:0], "call");
      op(OP_RET, 8'h00, 8'h00);
      pulled(ret);
      // masked requests pend, then are served by priority
      pulse(3'b111);
      chk(busy, 1'b0, "no entry");
      wb(1'b0, ADR_PEND, 32'h0, 4'hF);
      chk(q, 32'h7, "pending");
      chk(progCounter, expPc, "pc held");
      op(OP_SETG, 8'h00, 8'h00);
      foreach (vecs[i]) begin
         wait_entry(vecs[i]);
         pushed(expPc);
         op(OP_IRQ_EXIT, 8'h00, 8'h00);
         pulled(ret);
         chk(statusWord[F_G], 1'b1, "mask back");
      end
      wb(1'b0, ADR_PEND, 32'h0, 4'hF);
      chk(q, 32'h0, "served");
      wb(1'b0, ADR_SP, 32'h0, 4'hF);
      chk(q, {28'h0, expSp}, "sp pull");
      // trap taken with the mask clear
      expSt[F_G] = 1'b0;
      wb(1'b1, ADR_SR, {26'h0, expSt}, 4'hF);
      op(OP_TRAP, 8'h00, 8'h00);
      chk(progCounter, VTR, "trap");
      chk(statusWord[F_G], 1'b0, "trap mask");
      pushed(ret);
      op(OP_RET, 8'h00, 8'h00);
      pulled(ret);
      // effective address in every mode, random pointer and operands
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         @(posedge core_clk);
         addrMode <= i[1:0];
         xPtr <= r[11:0];
         opA <= r[19:12];
         opB <= r[27:20];
         @(posedge core_clk);
         #1;
         q = {20'h0, ea(i[1:0], r[11:0], r[19:12], r[27:20])};
         chk(effAddr, q, "ea");
      end
      close_out();
   end
endmodule // testbench
